/* File: rtl/cal_regs_defines.svh */
/*
 Offsets, field positions, reset values and counts for the calibration register bank.
 Assumes inclusion by bare name from the package and the design modules.
*/
// How it works
// - Calibration state reads at bits 5:4; 00 none, 01 self, 11 user.
// - Bits 2:0 select calibration clock divide 256 down to 2; reset 000.
// - Control bit 7 reads 1 once a calibration cycle finished; reset 0.
// - Writing 1 to control bit 6 starts the self-calibration cycle.
// - Control bit 3 stores coefficient data at the selected address.
// - Control bit 2 fetches the selected coefficient into the data register.
// - Control bit 0 restores every coefficient to its uncalibrated default.
// - Six-bit coefficient address, read/write, resets to zero.
// - Six-bit coefficient data, read/write, resets to all ones.
// - Register 0x00 bit 0 selects external reference; zero keeps internal.
// - Calibration clock runs only while its enable bit is one.
`ifndef CAL_REGS_DEFINES_SVH
`define CAL_REGS_DEFINES_SVH
`define ADDR_SPI_CTL 5'h00
`define ADDR_DATA_CTL 5'h02
`define ADDR_CAL_CONFIG 5'h0E
`define ADDR_CAL_CONTROL 5'h0F
`define ADDR_COEFF_INDEX 5'h10
`define ADDR_COEFF_VALUE 5'h11
`define BIT_EXT_REF 0
`define BIT_CAL_CLK_EN 0
`define BIT_DONE 7
`define BIT_START 6
`define BIT_WRITE 3
`define BIT_READ 2
`define BIT_CLEAR 0
`define COEFF_INDEX_RST 6'h00
`define COEFF_VALUE_RST 6'h3F
`define COEFF_DEFAULT 6'h20
`define DIVIDE_RST 3'h0
`define SRC_COEFF_CLEAR_STROBE 2'h0
`define SRC_SELF 2'h1
`define SRC_USER 2'h3
`define CAL_STEPS_PER_WORD 4
`endif

/* File: rtl/cal_regs_pkg.sv */
/*
 Types shared by the calibration register bank modules.
 Assumes the defines header sits beside it.
*/
`include "cal_regs_defines.svh"
package cal_regs_pkg;
    typedef enum logic [1:0] {
        cal_idle,
        cal_run,
        cal_done
    } cal_state_t;
    typedef logic [5:0] coeff_t;
endpackage : cal_regs_pkg

/* File: rtl/cal_mem_if.sv */
/*
 Interface carrying coefficient memory accesses between the bank and its store.
 Assumes one clock; write, clear and read act on the same edge they are seen.
*/
`timescale 1ns/10ps
interface cal_mem_if #(parameter int AW = 6);
    import cal_regs_pkg::*;
    logic wr_en;
    logic clr_all;
    logic [AW-1:0] addr;
    coeff_t wdata;
    coeff_t rdata;
    modport ctrl (output wr_en, output clr_all, output addr, output wdata, input rdata);
    modport mem (input wr_en, input clr_all, input addr, input wdata, output rdata);
endinterface : cal_mem_if

/* File: rtl/coeff_store.sv */
/*
 Static coefficient store: one word per address, bulk clear to default.
 Assumes one access per cycle from the register bank; read is registered.
*/
`timescale 1ns/10ps
`include "cal_regs_defines.svh"
module coeff_store
    import cal_regs_pkg::*;
#(
    parameter int DEPTH = 64
) (
    input wire logic ref_clk, // Conversion clock
    input wire logic rst_n, // Sync reset, active low
    cal_mem_if.mem bus // Access port
);
    coeff_t mem_q [DEPTH];
    coeff_t mem_d [DEPTH];
    coeff_t rd_q;
    coeff_t rd_d;

    initial begin
        assert (DEPTH >= 2 && DEPTH <= 64) else $error("DEPTH out of range");
    end

    always_comb begin
        mem_d = mem_q;
        rd_d = mem_q[bus.addr];
        if (bus.clr_all) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_d[i] = `COEFF_DEFAULT;
            end
        end else if (bus.wr_en) begin
            mem_d[bus.addr] = bus.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= `COEFF_DEFAULT;
            end
            rd_q <= 6'h00;
        end else begin
            mem_q <= mem_d;
            rd_q <= rd_d;
        end
    end

    assign bus.rdata = rd_q;
endmodule : coeff_store

/* File: rtl/cal_divider.sv */
/*
 Calibration clock divider: a free counter gives a one-cycle tick per period.
 Assumes divide code changes only while the gate is off; stray ticks are harmless.
*/
`timescale 1ns/10ps
`include "cal_regs_defines.svh"
module cal_divider (
    input wire logic ref_clk, // Conversion clock
    input wire logic rst_n, // Sync reset, active low
    input wire logic enable, // Gate for the calibration clock
    input wire logic [2:0] divide, // Divide code
    output logic tick // One cycle per calibration clock period
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] last;
    logic tick_q;
    logic tick_d;

    always_comb begin
        last = 8'(8'hFF >> divide);
        tick_d = 1'b0;
        cnt_d = 8'h00;
        if (enable) begin
            if (cnt_q >= last) begin
                tick_d = 1'b1;
            end else begin
                cnt_d = 8'(cnt_q + 8'h01);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule : cal_divider

/* File: rtl/cal_regs.sv */
/*
 Calibration register bank: reference select, calibration clock gating and
 divide, self-calibration sequencing and indirect coefficient memory access.
 Assumes a serial-port front end that hands over decoded byte writes and reads
 on a five-bit register address, one access per cycle, synchronous to ref_clk.
*/
`timescale 1ns/10ps
`include "cal_regs_defines.svh"
module cal_regs
    import cal_regs_pkg::*;
#(
    parameter int STEPS = `CAL_STEPS_PER_WORD
) (
    input wire logic ref_clk, // Conversion clock, 40 MHz
    input wire logic rst_n, // Sync reset, active low
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    input wire logic [4:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data byte
    output logic [7:0] reg_rdata, // Read data byte, registered
    output logic reg_rvalid, // Read data valid pulse
    output logic external_ref_select, // High selects external reference
    output logic cal_clock_gate, // Calibration clock enabled
    output logic cal_busy // Self-calibration running
);
    logic ext_ref_q, ext_ref_d;
    logic clk_en_q, clk_en_d;
    logic [2:0] cal_clock_divide_q, cal_clock_divide_d;
    logic [1:0] cal_source_state_q, cal_source_state_d;
    logic cal_done_flag_q, cal_done_flag_d;
    coeff_t coeff_index_q, coeff_index_d;
    coeff_t coeff_value_q, coeff_value_d;
    logic rd_pend_q, rd_pend_d;
    cal_state_t state_q, state_d;
    coeff_t step_addr_q, step_addr_d;
    logic [7:0] step_cnt_q, step_cnt_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic busy_q, busy_d;
    logic cal_tick;
    logic wr_cfg, wr_ctl, wr_idx, wr_val;

    cal_mem_if #(.AW(6)) mem_bus ();

    initial begin
        assert (STEPS >= 1 && STEPS <= 255) else $error("STEPS out of range");
    end

    cal_divider u_div (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .enable(clk_en_q),
        .divide(cal_clock_divide_q),
        .tick(cal_tick)
    );

    coeff_store #(.DEPTH(64)) u_store (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .bus(mem_bus)
    );

    assign wr_cfg = reg_wr && reg_addr == `ADDR_CAL_CONFIG;
    assign wr_ctl = reg_wr && reg_addr == `ADDR_CAL_CONTROL;
    assign wr_idx = reg_wr && reg_addr == `ADDR_COEFF_INDEX;
    assign wr_val = reg_wr && reg_addr == `ADDR_COEFF_VALUE;

    // Plain configuration bits
    always_comb begin
        ext_ref_d = ext_ref_q;
        clk_en_d = clk_en_q;
        cal_clock_divide_d = cal_clock_divide_q;
        coeff_index_d = coeff_index_q;
        if (reg_wr && reg_addr == `ADDR_SPI_CTL) begin
            ext_ref_d = reg_wdata[`BIT_EXT_REF];
        end
        if (reg_wr && reg_addr == `ADDR_DATA_CTL) begin
            clk_en_d = reg_wdata[`BIT_CAL_CLK_EN];
        end
        if (wr_cfg) begin
            cal_clock_divide_d = reg_wdata[2:0];
        end
        if (wr_idx) begin
            coeff_index_d = reg_wdata[5:0];
        end
    end

    // Calibration sequence and coefficient actions
    always_comb begin
        state_d = state_q;
        step_addr_d = step_addr_q;
        step_cnt_d = step_cnt_q;
        cal_done_flag_d = cal_done_flag_q;
        cal_source_state_d = cal_source_state_q;
        coeff_value_d = coeff_value_q;
        rd_pend_d = 1'b0;
        mem_bus.wr_en = 1'b0;
        mem_bus.clr_all = 1'b0;
        mem_bus.addr = coeff_index_q;
        mem_bus.wdata = coeff_value_q;
        if (wr_val) begin
            coeff_value_d = reg_wdata[5:0];
        end
        if (rd_pend_q) begin
            coeff_value_d = mem_bus.rdata;
        end
        unique case (state_q)
            cal_idle, cal_done: begin
                if (wr_ctl && reg_wdata[`BIT_START]) begin
                    state_d = cal_run;
                    cal_done_flag_d = 1'b0;
                    step_addr_d = 6'h00;
                    step_cnt_d = 8'h00;
                end else if (wr_ctl && reg_wdata[`BIT_CLEAR]) begin
                    mem_bus.clr_all = 1'b1;
                    cal_source_state_d = `SRC_COEFF_CLEAR_STROBE;
                end else if (wr_ctl && reg_wdata[`BIT_WRITE]) begin
                    mem_bus.wr_en = 1'b1;
                    cal_source_state_d = `SRC_USER;
                end else if (wr_ctl && reg_wdata[`BIT_READ]) begin
                    rd_pend_d = 1'b1;
                end
            end
            cal_run: begin
                mem_bus.addr = step_addr_q;
                mem_bus.wdata = `COEFF_DEFAULT;
                if (cal_tick) begin
                    if (step_cnt_q == 8'(STEPS - 1)) begin
                        step_cnt_d = 8'h00;
                        mem_bus.wr_en = 1'b1;
                        if (step_addr_q == 6'h3F) begin
                            state_d = cal_done;
                            cal_done_flag_d = 1'b1;
                            cal_source_state_d = `SRC_SELF;
                        end else begin
                            step_addr_d = 6'(step_addr_q + 6'h01);
                        end
                    end else begin
                        step_cnt_d = 8'(step_cnt_q + 8'h01);
                    end
                end
            end
        endcase
        // Registered so the busy output comes straight from a flop
        busy_d = state_d == cal_run;
    end

    // Read mux; control action bits always read as zero
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = reg_rd;
        if (reg_rd) begin
            unique case (reg_addr)
                `ADDR_SPI_CTL: rdata_d = {7'h00, ext_ref_q};
                `ADDR_DATA_CTL: rdata_d = {7'h00, clk_en_q};
                `ADDR_CAL_CONFIG: rdata_d = {2'h0, cal_source_state_q, 1'b0,
                    cal_clock_divide_q};
                `ADDR_CAL_CONTROL: rdata_d = {cal_done_flag_q, 7'h00};
                `ADDR_COEFF_INDEX: rdata_d = {2'h0, coeff_index_q};
                `ADDR_COEFF_VALUE: rdata_d = {2'h0, coeff_value_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ext_ref_q <= 1'b0;
            clk_en_q <= 1'b0;
            cal_clock_divide_q <= `DIVIDE_RST;
            cal_source_state_q <= `SRC_COEFF_CLEAR_STROBE;
            cal_done_flag_q <= 1'b0;
            coeff_index_q <= `COEFF_INDEX_RST;
            coeff_value_q <= `COEFF_VALUE_RST;
            rd_pend_q <= 1'b0;
            state_q <= cal_idle;
            step_addr_q <= 6'h00;
            step_cnt_q <= 8'h00;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            ext_ref_q <= ext_ref_d;
            clk_en_q <= clk_en_d;
            cal_clock_divide_q <= cal_clock_divide_d;
            cal_source_state_q <= cal_source_state_d;
            cal_done_flag_q <= cal_done_flag_d;
            coeff_index_q <= coeff_index_d;
            coeff_value_q <= coeff_value_d;
            rd_pend_q <= rd_pend_d;
            state_q <= state_d;
            step_addr_q <= step_addr_d;
            step_cnt_q <= step_cnt_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            busy_q <= busy_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign external_ref_select = ext_ref_q;
    assign cal_clock_gate = clk_en_q;
    assign cal_busy = busy_q;
endmodule : cal_regs

/* File: test/cal_regs_monitor.sv */
/*
 Port checker for the calibration register bank.
 Assumes it is bound onto cal_regs and runs on its single clock.
*/
`timescale 1ns/10ps
module cal_regs_monitor (
    input wire logic ref_clk, // Clock
    input wire logic rst_n, // Sync reset
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [4:0] reg_addr, // Address
    input wire logic [7:0] reg_wdata, // Write byte
    input wire logic [7:0] reg_rdata, // Read byte
    input wire logic reg_rvalid, // Read valid
    input wire logic external_ref_select, // Reference select
    input wire logic cal_clock_gate, // Clock gate
    input wire logic cal_busy // Busy
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    wire wr_ctl = reg_wr && reg_addr == 5'h0F;
    wire rd_ctl = reg_rd && reg_addr == 5'h0F;
    rd_valid_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    ext_ref_a: assert property (reg_wr && reg_addr == 5'h00 |=>
        external_ref_select == $past(reg_wdata[0])) else $error("reference select wrong");
    ext_hold_a: assert property (!(reg_wr && reg_addr == 5'h00) |=>
        $stable(external_ref_select)) else $error("reference select moved");
    clk_gate_a: assert property (reg_wr && reg_addr == 5'h02 |=>
        cal_clock_gate == $past(reg_wdata[0])) else $error("clock gate wrong");
    cal_start_a: assert property (wr_ctl && reg_wdata[6] && cal_clock_gate && !cal_busy
        |-> ##[1:3] cal_busy) else $error("calibration did not start");
    busy_span_a: assert property ($rose(cal_busy) |-> cal_busy[*8])
        else $error("calibration too short");
    busy_done_a: assert property (rd_ctl && cal_busy |=> !reg_rdata[7])
        else $error("done while busy");
    ctl_bits_a: assert property (rd_ctl |=> reg_rdata[5:0] == 6'h00)
        else $error("action bits read back");
    cfg_bits_a: assert property (reg_rd && reg_addr == 5'h0E |=>
        reg_rdata[7:6] == 2'h0 && reg_rdata[5:4] != 2'h2 && !reg_rdata[3])
        else $error("config read bad");
    idx_bits_a: assert property (reg_rd && reg_addr[4:1] == 4'h8 |=>
        reg_rdata[7:6] == 2'h0) else $error("coefficient read too wide");
    cover property (wr_ctl && reg_wdata[3]);
    cover property (wr_ctl && reg_wdata[0]);
    cover property ($fell(cal_busy));
endmodule : cal_regs_monitor
bind cal_regs cal_regs_monitor cal_regs_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cal_busy(cal_busy),
    .external_ref_select(external_ref_select), .cal_clock_gate(cal_clock_gate));

/* File: test/cal_host_model.sv */
/*
 Host model: single-byte register writes and reads, one idle cycle after each.
 Assumes its task is entered just past a rising edge, after reset.
*/
`timescale 1ns/10ps
module cal_host_model (
    input wire logic ref_clk, // Clock
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output logic [4:0] reg_addr, // Address
    output logic [7:0] reg_wdata // Write byte
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h1F;
        reg_wdata = 8'hA5;
    end
    task automatic access(input logic wr, input logic [4:0] ra, input logic [7:0] rv);
        reg_addr = ra;
        reg_wdata = rv;
        reg_wr = wr;
        reg_rd = !wr;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // Released lines invert so stale values never pass
        reg_addr = ~ra;
        reg_wdata = ~rv;
        @(posedge ref_clk);
        #1;
    endtask : access
endmodule : cal_host_model

/* File: test/test_cal_regs.sv */
/*
 Self-checking bench for the calibration register bank.
 Assumes the host model and the bound checker are compiled with it.
*/
`timescale 1ns/10ps
`include "cal_regs_defines.svh"
module test_cal_regs;
    import cal_regs_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd, reg_rvalid, external_ref_select, cal_clock_gate, cal_busy;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    int n_mismatch = 0;
    int checks_done = 0;
    int busy_cycles = 0;
    logic [7:0] expect_q[$];
    coeff_t a, d;
    always #12.5 ref_clk = ~ref_clk;
    cal_host_model cal_host_model_i (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    // One tick per word keeps the calibration run short
    cal_regs #(.STEPS(1)) cal_regs_i (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .external_ref_select(external_ref_select),
        .cal_clock_gate(cal_clock_gate), .cal_busy(cal_busy));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [4:0] ra, input logic [7:0] rv);
        cal_host_model_i.access(1'b1, ra, rv);
    endtask : wr
    task automatic rd(input logic [4:0] ra, input logic [7:0] ev);
        expect_q.push_back(ev);
        cal_host_model_i.access(1'b0, ra, 8'h00);
    endtask : rd
    task automatic complete_run();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    always @(posedge ref_clk) begin
        if (cal_busy === 1'b1)
            busy_cycles++;
        if (reg_rvalid === 1'b1)
            check(reg_rdata, expect_q.size() > 0 ? expect_q.pop_front() : 8'hXX);
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        a = 6'h00;
        d = 6'h00;
        void'($urandom(84143));
        repeat (3) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        rd(5'h0E, 8'h00);
        rd(5'h0F, 8'h00);
        rd(5'h10, 8'h00);
        rd(5'h11, 8'h3F);
        rd(5'h00, 8'h00);
        rd(5'h02, 8'h00);
        wr(5'h05, 8'hFF);
        rd(5'h05, 8'h00);
        wr(5'h00, 8'h01);
        check({7'h00, external_ref_select}, 8'h01);
        rd(5'h00, 8'h01);
        wr(5'h00, 8'h00);
        check({7'h00, external_ref_select}, 8'h00);
        wr(5'h02, 8'h01);
        check({7'h00, cal_clock_gate}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            wr(5'h0E, 8'(i));
            rd(5'h0E, 8'(i));
        end
        for (int i = 0; i < 3; i++) begin
            a = 6'($urandom());
            d = 6'($urandom());
            wr(5'h10, {2'h0, a});
            wr(5'h11, {2'h0, d});
            wr(5'h0F, 8'h08);
            rd(5'h0E, 8'h37);
            wr(5'h11, {2'h0, ~d});
            wr(5'h0F, 8'h04);
            rd(5'h11, {2'h0, d});
            rd(5'h10, {2'h0, a});
            rd(5'h0F, 8'h00);
        end
        wr(5'h0F, 8'h01);
        rd(5'h0E, 8'h07);
        wr(5'h0F, 8'h04);
        rd(5'h11, {2'h0, `COEFF_DEFAULT});
        wr(5'h0F, 8'h40);
        check({7'h00, cal_busy}, 8'h01);
        rd(5'h0F, 8'h00);
        for (int n = 0; n < 1000 && cal_busy === 1'b1; n++)
            @(posedge ref_clk);
        #1;
        check({7'h00, cal_busy}, 8'h00);
        // 64 words, one step each, divide by 2: one cycle less if a tick lands at once
        check(8'(busy_cycles >= 127 && busy_cycles <= 128), 8'h01);
        rd(5'h0F, 8'h80);
        rd(5'h0E, 8'h17);
        complete_run();
    end
endmodule : test_cal_regs
